// ===== hw/modulation_control.sv
// Transmit modulation control with AHB-Lite register access
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - two-bit selector picks FSK, GFSK, amplitude, MSK
// - FSK deviation from mantissa and exponent formula
// - mantissa three bits, exponent four bits, 0..9
// - GFSK Gaussian product selectable as 1 or 0.5
// - MSK ignores deviation fields, uses quarter rate
// - amplitude mode is ASK with ramp, else OOK
// - OOK ones at top level, zeros entry 0
// - ASK ones ramp up, zeros ramp down
// - each ASK step lasts one eighth symbol
// - repeated ones stay at top level
// - repeated zeros stay at entry 0
// - carrier enable gives unmodulated carrier
// - single host bit enables power ramping
// - three-bit top index limits table to eight
// - ASK index counter steps at eight times symbol rate
// - level word zero switches output stage off
module modulation_control #(
  parameter int unsigned LEVEL_WIDTH = 7
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Transmit bit stream
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  output logic tx_bit_ready,
  // Synthesizer side
  output modulation_pkg::synth_ctrl_t synth_ctrl,
  output logic [modulation_pkg::DEVWORD_W-1:0] deviation_word,
  // Power amplifier side
  output logic [LEVEL_WIDTH-1:0] power_level_word,
  output logic output_stage_off
);

  if (LEVEL_WIDTH < 1 || LEVEL_WIDTH > 16) begin : g_check
    $error("modulation_control: LEVEL_WIDTH must be 1..16");
  end

  localparam int unsigned IW = modulation_pkg::IDX_W;
  localparam int unsigned SW = modulation_pkg::STEP_W;

  // True when a byte address hits the level table
  function automatic logic is_table(input logic [7:0] a);
    return a[7:modulation_pkg::TABLE_SEL_LSB] == modulation_pkg::TABLE_SEL;
  endfunction : is_table

  // Software registers
  modulation_pkg::mod_t modulation_select_reg;
  logic gaussian_product_select_reg;
  logic unmodulated_carrier_enable_reg;
  logic [modulation_pkg::DEV_M_W-1:0] deviation_mantissa_reg;
  logic [modulation_pkg::DEV_E_W-1:0] deviation_exponent_reg;
  logic [modulation_pkg::RATE_M_W-1:0] rate_mantissa_reg;
  logic [modulation_pkg::RATE_E_W-1:0] rate_exponent_reg;
  logic power_ramp_on_reg;
  logic [IW-1:0] top_level_index_reg;
  logic [SW-1:0] step_cycles_reg;
  logic tx_enable_reg;
  logic underrun_reg;

  // Bus pipeline
  logic accept;
  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  logic [1:0] rd_wait_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] read_mux;
  logic wr_en;
  logic [LEVEL_WIDTH-1:0] table_a_q;
  logic [LEVEL_WIDTH-1:0] table_b_q;
  logic exponent_invalid;

  // Transmit engine
  modulation_pkg::tx_settings_t settings_next;
  modulation_pkg::tx_settings_t settings_reg;
  logic active_reg;
  logic entering;
  logic [SW-1:0] step_len;
  logic [SW-1:0] step_cnt_reg;
  logic [IW-1:0] sub_step_reg;
  logic step_tick;
  logic boundary;
  logic new_bit;
  logic bit_now;
  logic cur_bit_reg;
  logic [IW-1:0] level_index_reg;
  logic ask_on;

  // Address phase is taken only when the bus is ready and a transfer is real
  assign accept = hsel && hready && htrans[1];
  assign wr_en = dp_write_reg;
  assign hreadyout = (rd_wait_reg == 2'h0);
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // Data phase bookkeeping; reads take two wait states for the table read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      rd_wait_reg <= 2'h0;
    end else begin
      dp_write_reg <= accept && hwrite;
      if (accept) begin
        dp_addr_reg <= haddr[modulation_pkg::ADDR_W-1:0];
      end
      if (accept && !hwrite) begin
        rd_wait_reg <= modulation_pkg::READ_WAIT;
      end else if (rd_wait_reg != 2'h0) begin
        rd_wait_reg <= rd_wait_reg - 2'h1;
      end
    end
  end

  // Register writes; unmapped addresses are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modulation_select_reg <= modulation_pkg::mod_t'(modulation_pkg::RST_SEL);
      gaussian_product_select_reg <= 1'b0;
      unmodulated_carrier_enable_reg <= 1'b0;
      deviation_mantissa_reg <= modulation_pkg::RST_DEV_M;
      deviation_exponent_reg <= modulation_pkg::RST_DEV_E;
      rate_mantissa_reg <= modulation_pkg::RST_RATE_M;
      rate_exponent_reg <= modulation_pkg::RST_RATE_E;
      power_ramp_on_reg <= 1'b0;
      top_level_index_reg <= modulation_pkg::RST_TOP;
      step_cycles_reg <= modulation_pkg::RST_STEP;
      tx_enable_reg <= 1'b0;
    end else if (wr_en) begin
      unique case (dp_addr_reg)
        modulation_pkg::OFF_MODCTRL: begin
          modulation_select_reg <= modulation_pkg::mod_t'(hwdata[modulation_pkg::MOD_SEL_LSB +: 2]);
          gaussian_product_select_reg <= hwdata[modulation_pkg::GAUSS_BIT];
          unmodulated_carrier_enable_reg <= hwdata[modulation_pkg::CW_BIT];
        end
        modulation_pkg::OFF_DEV: begin
          deviation_mantissa_reg <= hwdata[modulation_pkg::DEV_M_LSB +: 3];
          deviation_exponent_reg <= hwdata[modulation_pkg::DEV_E_LSB +: 4];
        end
        modulation_pkg::OFF_RATE: begin
          rate_mantissa_reg <= hwdata[modulation_pkg::RATE_M_LSB +: 8];
          rate_exponent_reg <= hwdata[modulation_pkg::RATE_E_LSB +: 4];
        end
        modulation_pkg::OFF_POWER: begin
          power_ramp_on_reg <= hwdata[modulation_pkg::RAMP_BIT];
          top_level_index_reg <= hwdata[modulation_pkg::TOP_LSB +: 3];
        end
        modulation_pkg::OFF_STEP: begin
          step_cycles_reg <= hwdata[SW-1:0];
        end
        modulation_pkg::OFF_TXCTRL: begin
          tx_enable_reg <= hwdata[modulation_pkg::TXEN_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Underrun is sticky, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      underrun_reg <= 1'b0;
    end else if (boundary && !tx_bit_valid) begin
      underrun_reg <= 1'b1;
    end else if (wr_en && dp_addr_reg == modulation_pkg::OFF_STATUS && hwdata[modulation_pkg::ST_UNDERRUN_BIT]) begin
      underrun_reg <= 1'b0;
    end
  end

  // Read multiplexer; reserved bits and unmapped words read as zero
  always_comb begin
    read_mux = 32'h0000_0000;
    if (is_table(dp_addr_reg)) begin
      read_mux[LEVEL_WIDTH-1:0] = table_a_q;
    end else begin
      unique case (dp_addr_reg)
        modulation_pkg::OFF_MODCTRL: begin
          read_mux[modulation_pkg::MOD_SEL_LSB +: 2] = modulation_select_reg;
          read_mux[modulation_pkg::GAUSS_BIT] = gaussian_product_select_reg;
          read_mux[modulation_pkg::CW_BIT] = unmodulated_carrier_enable_reg;
        end
        modulation_pkg::OFF_DEV: begin
          read_mux[modulation_pkg::DEV_M_LSB +: 3] = deviation_mantissa_reg;
          read_mux[modulation_pkg::DEV_E_LSB +: 4] = deviation_exponent_reg;
        end
        modulation_pkg::OFF_RATE: begin
          read_mux[modulation_pkg::RATE_M_LSB +: 8] = rate_mantissa_reg;
          read_mux[modulation_pkg::RATE_E_LSB +: 4] = rate_exponent_reg;
        end
        modulation_pkg::OFF_POWER: begin
          read_mux[modulation_pkg::RAMP_BIT] = power_ramp_on_reg;
          read_mux[modulation_pkg::TOP_LSB +: 3] = top_level_index_reg;
        end
        modulation_pkg::OFF_STEP: begin
          read_mux[SW-1:0] = step_cycles_reg;
        end
        modulation_pkg::OFF_TXCTRL: begin
          read_mux[modulation_pkg::TXEN_BIT] = tx_enable_reg;
        end
        modulation_pkg::OFF_STATUS: begin
          read_mux[modulation_pkg::ST_ACTIVE_BIT] = active_reg;
          read_mux[modulation_pkg::ST_UNDERRUN_BIT] = underrun_reg;
          read_mux[modulation_pkg::ST_EXPBAD_BIT] = exponent_invalid;
          read_mux[modulation_pkg::ST_IDX_LSB +: 3] = level_index_reg;
          read_mux[modulation_pkg::ST_MODE_LSB +: 2] = settings_reg.mode;
          read_mux[modulation_pkg::ST_ASK_BIT] = ask_on;
          read_mux[modulation_pkg::ST_DEV_LSB +: 12] = deviation_word;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data register loaded in the last wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_wait_reg == 2'h1) begin
      hrdata_reg <= read_mux;
    end
  end

  level_table #(
    .WIDTH(LEVEL_WIDTH),
    .DEPTH(1 << IW),
    .AW(IW)
  ) u_table (
    .clk(hclk),
    .rst_n(hresetn),
    .wr_en(wr_en && is_table(dp_addr_reg)),
    .wr_addr(dp_addr_reg[modulation_pkg::TABLE_IDX_LSB +: IW]),
    .wr_data(hwdata[LEVEL_WIDTH-1:0]),
    .a_rd_en(rd_wait_reg == modulation_pkg::READ_WAIT),
    .a_addr(dp_addr_reg[modulation_pkg::TABLE_IDX_LSB +: IW]),
    .a_q(table_a_q),
    .b_addr(level_index_reg),
    .b_q(table_b_q)
  );

  // Live register values that would be frozen on entry
  always_comb begin
    settings_next.mode = modulation_select_reg;
    settings_next.product_half = gaussian_product_select_reg;
    settings_next.carrier_only = unmodulated_carrier_enable_reg;
    settings_next.ramp_on = power_ramp_on_reg;
    settings_next.top = top_level_index_reg;
    settings_next.dev_m = deviation_mantissa_reg;
    settings_next.dev_e = deviation_exponent_reg;
    settings_next.rate_m = rate_mantissa_reg;
    settings_next.rate_e = rate_exponent_reg;
  end

  // Freeze settings so mid-packet writes wait for the next transmission; step length and level table writes act at once
  assign entering = tx_enable_reg && !active_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settings_reg <= '0;
      active_reg <= 1'b0;
    end else begin
      active_reg <= tx_enable_reg;
      if (entering) begin
        settings_reg <= settings_next;
      end
    end
  end

  deviation_unit u_dev (
    .clk(hclk),
    .rst_n(hresetn),
    .settings(settings_reg),
    .deviation_word(deviation_word),
    .exponent_invalid(exponent_invalid)
  );

  // Step timing: a zero step length behaves as one cycle
  assign step_len = (step_cycles_reg == '0) ? SW'(1) : step_cycles_reg;
  assign step_tick = active_reg && (step_cnt_reg == step_len - SW'(1));
  assign boundary = step_tick && (sub_step_reg == modulation_pkg::LAST_STEP);
  assign tx_bit_ready = boundary;
  assign new_bit = tx_bit_valid && tx_bit; // Starved stream sends zero
  assign bit_now = boundary ? new_bit : cur_bit_reg;
  assign ask_on = (settings_reg.mode == modulation_pkg::mod_amp) && settings_reg.ramp_on;

  // Eight steps per symbol; the first tick after entry opens a symbol
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_cnt_reg <= '0;
      sub_step_reg <= '0;
      cur_bit_reg <= 1'b0;
    end else if (entering) begin
      step_cnt_reg <= step_len - SW'(1);
      sub_step_reg <= modulation_pkg::LAST_STEP;
    end else if (active_reg) begin
      step_cnt_reg <= step_tick ? '0 : step_cnt_reg + SW'(1);
      if (step_tick) begin
        sub_step_reg <= sub_step_reg + IW'(1);
      end
      if (boundary) begin
        cur_bit_reg <= new_bit;
      end
    end
  end

  // Level index: ramps in ASK, jumps in OOK, fixed at top otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_index_reg <= '0;
    end else if (entering) begin
      level_index_reg <= (settings_next.mode == modulation_pkg::mod_amp && !settings_next.carrier_only) ?
                         '0 : settings_next.top;
    end else if (active_reg) begin
      if (settings_reg.carrier_only || settings_reg.mode != modulation_pkg::mod_amp) begin
        level_index_reg <= settings_reg.top;
      end else if (ask_on) begin
        if (step_tick && bit_now && level_index_reg < settings_reg.top) begin
          level_index_reg <= level_index_reg + IW'(1);
        end else if (step_tick && !bit_now && level_index_reg != '0) begin
          level_index_reg <= level_index_reg - IW'(1);
        end
      end else if (boundary) begin
        level_index_reg <= new_bit ? settings_reg.top : '0;
      end
    end
  end

  // Power word and stage off flag; idle transmitter drives zero level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_level_word <= '0;
      output_stage_off <= 1'b1;
    end else begin
      power_level_word <= active_reg ? table_b_q : '0;
      output_stage_off <= !active_reg || (table_b_q == '0);
    end
  end

  // Synthesizer control word, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      synth_ctrl <= '0;
    end else begin
      synth_ctrl.active <= active_reg;
      synth_ctrl.mode <= settings_reg.mode;
      synth_ctrl.ask <= ask_on;
      synth_ctrl.gauss_on <= (settings_reg.mode == modulation_pkg::mod_gfsk) && !settings_reg.carrier_only;
      synth_ctrl.gauss_half <= settings_reg.product_half;
      synth_ctrl.carrier_only <= settings_reg.carrier_only;
      synth_ctrl.data_bit <= settings_reg.carrier_only ? 1'b0 : cur_bit_reg;
    end
  end

endmodule : modulation_control

// ===== hw/modulation_pkg.sv
// Constants, register map and carrier types of the modulation control block
package modulation_pkg;

  // Register byte offsets (low address bits only are decoded)
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_MODCTRL = 8'h00;
  localparam logic [7:0] OFF_DEV = 8'h04;
  localparam logic [7:0] OFF_RATE = 8'h08;
  localparam logic [7:0] OFF_POWER = 8'h0C;
  localparam logic [7:0] OFF_STEP = 8'h10;
  localparam logic [7:0] OFF_TXCTRL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // Level table occupies 0x20..0x3C, selected by address bits [7:5]
  localparam logic [2:0] TABLE_SEL = 3'h1;
  localparam int unsigned TABLE_SEL_LSB = 5;
  localparam int unsigned TABLE_IDX_LSB = 2;

  // Field widths
  localparam int unsigned SEL_W = 2;
  localparam int unsigned DEV_M_W = 3;
  localparam int unsigned DEV_E_W = 4;
  localparam int unsigned RATE_M_W = 8;
  localparam int unsigned RATE_E_W = 4;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned DEVWORD_W = 12;
  localparam int unsigned STEP_W = 16;

  // Field positions
  localparam int unsigned MOD_SEL_LSB = 0;
  localparam int unsigned GAUSS_BIT = 2;
  localparam int unsigned CW_BIT = 3;
  localparam int unsigned DEV_M_LSB = 0;
  localparam int unsigned DEV_E_LSB = 4;
  localparam int unsigned RATE_M_LSB = 0;
  localparam int unsigned RATE_E_LSB = 8;
  localparam int unsigned RAMP_BIT = 0;
  localparam int unsigned TOP_LSB = 4;
  localparam int unsigned TXEN_BIT = 0;
  localparam int unsigned ST_ACTIVE_BIT = 0;
  localparam int unsigned ST_UNDERRUN_BIT = 1;
  localparam int unsigned ST_EXPBAD_BIT = 2;
  localparam int unsigned ST_IDX_LSB = 4;
  localparam int unsigned ST_MODE_LSB = 8;
  localparam int unsigned ST_ASK_BIT = 10;
  localparam int unsigned ST_DEV_LSB = 12;

  // Reset values
  localparam logic [SEL_W-1:0] RST_SEL = 2'h0;
  localparam logic [DEV_M_W-1:0] RST_DEV_M = 3'h0;
  localparam logic [DEV_E_W-1:0] RST_DEV_E = 4'h0;
  localparam logic [RATE_M_W-1:0] RST_RATE_M = 8'h00;
  localparam logic [RATE_E_W-1:0] RST_RATE_E = 4'h0;
  localparam logic [IDX_W-1:0] RST_TOP = 3'h0;
  localparam logic [STEP_W-1:0] RST_STEP = 16'h0001;

  // Deviation arithmetic
  localparam logic [DEV_E_W-1:0] DEV_E_MAX = 4'h9;
  localparam logic [12:0] DEV_BASE = 13'h0008;
  localparam logic [23:0] RATE_BASE = 24'h000100;
  // Quarter of the data rate expressed in synthesizer deviation units
  localparam int unsigned MSK_SHIFT = 12;

  // Ramp steps per symbol, last step index of a symbol; bus read wait states
  localparam logic [IDX_W-1:0] LAST_STEP = 3'h7;
  localparam logic [1:0] READ_WAIT = 2'h2;

  // Modulation selector, in selector code order
  typedef enum logic [SEL_W-1:0] {mod_fsk, mod_gfsk, mod_amp, mod_msk} mod_t;

  // Settings frozen at the start of a transmission
  typedef struct packed {
    mod_t mode;
    logic product_half;
    logic carrier_only;
    logic ramp_on;
    logic [IDX_W-1:0] top;
    logic [DEV_M_W-1:0] dev_m;
    logic [DEV_E_W-1:0] dev_e;
    logic [RATE_M_W-1:0] rate_m;
    logic [RATE_E_W-1:0] rate_e;
  } tx_settings_t;

  // Control word towards the frequency synthesizer
  typedef struct packed {
    logic active;
    mod_t mode;
    logic ask;
    logic gauss_on;
    logic gauss_half;
    logic carrier_only;
    logic data_bit;
  } synth_ctrl_t;

endpackage : modulation_pkg

// ===== hw/level_table.sv
// Output level table: one write port, two registered read ports
`timescale 1ns/1ps
module level_table #(
  parameter int unsigned WIDTH = 7,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Bus read port
  input wire logic a_rd_en,
  input wire logic [AW-1:0] a_addr,
  output logic [WIDTH-1:0] a_q,
  // Level lookup port, read every cycle
  input wire logic [AW-1:0] b_addr,
  output logic [WIDTH-1:0] b_q
);

  if (DEPTH != (1 << AW) || WIDTH < 1 || WIDTH > 32) begin : g_check
    $error("level_table: DEPTH must be 2**AW and WIDTH 1..32");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Storage; reset to zero so every level starts switched off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Bus read data, loaded only when asked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= '0;
    end else if (a_rd_en) begin
      a_q <= mem_reg[a_addr];
    end
  end

  // Lookup read data, one cycle behind the index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b_q <= '0;
    end else begin
      b_q <= mem_reg[b_addr];
    end
  end

endmodule : level_table

// ===== hw/deviation_unit.sv
// Frequency deviation word from the frozen transmit settings
`timescale 1ns/1ps
module deviation_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Frozen settings
  input wire modulation_pkg::tx_settings_t settings,
  // Result
  output logic [modulation_pkg::DEVWORD_W-1:0] deviation_word,
  output logic exponent_invalid
);

  // floor((8 + m) * 2^(e - 1)); exponents above the valid range saturate
  function automatic logic [11:0] fsk_dev(input logic [2:0] m, input logic [3:0] e);
    logic [3:0] ee;
    logic [12:0] v;
    ee = (e > modulation_pkg::DEV_E_MAX) ? modulation_pkg::DEV_E_MAX : e;
    v = (modulation_pkg::DEV_BASE + {10'h000, m}) << ee;
    return v[12:1];
  endfunction : fsk_dev

  // Quarter of the data rate, assuming digital clock equals the reference
  function automatic logic [11:0] msk_dev(input logic [7:0] m, input logic [3:0] e);
    logic [23:0] v;
    logic [23:0] s;
    v = (modulation_pkg::RATE_BASE + {16'h0000, m}) << e;
    s = v >> modulation_pkg::MSK_SHIFT;
    return s[11:0];
  endfunction : msk_dev

  // Registered so the synthesizer sees a clean word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deviation_word <= '0;
    end else if (settings.carrier_only) begin
      deviation_word <= '0;
    end else begin
      unique case (settings.mode)
        modulation_pkg::mod_fsk, modulation_pkg::mod_gfsk: begin
          deviation_word <= fsk_dev(settings.dev_m, settings.dev_e);
        end
        modulation_pkg::mod_msk: begin
          deviation_word <= msk_dev(settings.rate_m, settings.rate_e);
        end
        modulation_pkg::mod_amp: begin
          deviation_word <= '0;
        end
      endcase
    end
  end

  // Flag an exponent outside 0..9 in every mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exponent_invalid <= 1'b0;
    end else begin
      exponent_invalid <= (settings.dev_e > modulation_pkg::DEV_E_MAX);
    end
  end

endmodule : deviation_unit

// ===== test/modulation_props.sv
// Port assertions for the modulation control block
`timescale 1ns/1ps
module modulation_props #(
  parameter int unsigned LEVEL_WIDTH = 7
) (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Radio side
  input wire logic tx_bit_ready,
  input wire modulation_pkg::synth_ctrl_t synth_ctrl,
  input wire logic [11:0] deviation_word,
  input wire logic [LEVEL_WIDTH-1:0] power_level_word,
  input wire logic output_stage_off
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic tk;
  // Transfer taken at this edge
  assign tk = hsel && hready && htrans[1];
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
  a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout) else $error("read wait");
  a_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write wait");
  a_stage_off: assert property (output_stage_off == (power_level_word == 0)) else $error("stage off");
  a_carrier_flat: assert property (synth_ctrl.active [*3] ##0 synth_ctrl.carrier_only
    |-> deviation_word == 0 && !synth_ctrl.data_bit) else $error("carrier modulated");
  a_ask_amp: assert property (synth_ctrl.ask |-> synth_ctrl.mode == modulation_pkg::mod_amp) else $error("ask");
  a_gauss_gfsk: assert property (synth_ctrl.active && !synth_ctrl.carrier_only
    |-> synth_ctrl.gauss_on == (synth_ctrl.mode == modulation_pkg::mod_gfsk)) else $error("gauss");
  a_symbol_gap: assert property (tx_bit_ready |=> !tx_bit_ready [*7]) else $error("symbol short");
  a_frozen_cfg: assert property (synth_ctrl.active [*4]
    |-> $stable(deviation_word) && $stable(synth_ctrl.mode)) else $error("settings moved");
endmodule : modulation_props
bind modulation_control modulation_props #(.LEVEL_WIDTH(LEVEL_WIDTH)) props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .tx_bit_ready(tx_bit_ready), .synth_ctrl(synth_ctrl), .deviation_word(deviation_word),
  .power_level_word(power_level_word), .output_stage_off(output_stage_off));

// ===== test/bit_source.sv
// Bit source model feeding the transmit stream
`timescale 1ns/1ps
module bit_source (
  // Clock and restart
  input wire logic clk,
  input wire logic rst_n,
  // Pattern and handshake
  input wire logic [7:0] pattern,
  input wire logic ready,
  output logic bit_out
);
  logic [2:0] idx_reg;
  // Advance on each taken bit; the pattern repeats every eight symbols
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) idx_reg <= 3'h0;
    else if (ready) idx_reg <= idx_reg + 3'h1;
  end
  assign bit_out = pattern[idx_reg];
endmodule : bit_source

// ===== test/tb_modulation_control.sv
// Self-checking bench for the modulation control block
`timescale 1ns/1ps
module tb_modulation_control;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, restart = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [7:0] pattern = 8'h00;
  logic hreadyout, hresp, tx_bit, tx_bit_ready, output_stage_off;
  logic [11:0] deviation_word;
  logic [6:0] power_level_word, l1;
  modulation_pkg::synth_ctrl_t synth_ctrl;
  logic [31:0] dv [6] = '{32'h00, 32'h07, 32'h97, 32'hC1, 32'h20, 32'h20};
  int fails = 0, checked = 0, cyc = 0, e;
  // 125 MHz clock
  always #4 hclk = ~hclk;
  modulation_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_bit(tx_bit), .tx_bit_valid(1'b1), .tx_bit_ready(tx_bit_ready), .synth_ctrl(synth_ctrl),
    .deviation_word(deviation_word), .power_level_word(power_level_word), .output_stage_off(output_stage_off));
  bit_source src (.clk(hclk), .rst_n(hresetn & ~restart), .pattern(pattern), .ready(tx_bit_ready),
    .bit_out(tx_bit));
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  // One single transfer; waits on hready in both phases, read data kept in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    r = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd
  // Stop (the transmitter halts at once), idle 40 cycles, configure, restart the source, enable
  task automatic go(input logic [31:0] mc, input logic [31:0] pw);
    bus(1'b1, 8'h14, 32'h0);
    repeat (40) @(posedge hclk);
    bus(1'b1, 8'h00, mc);
    bus(1'b1, 8'h0C, pw);
    restart <= 1'b1;
    @(posedge hclk);
    restart <= 1'b0;
    bus(1'b1, 8'h14, 32'h1);
  endtask : go
  task automatic sym(input int n);
    do @(posedge hclk); while (!tx_bit_ready);
    repeat (n) @(posedge hclk);
  endtask : sym
  // Hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk(32'(output_stage_off), 32'h1);
    rd(8'h10, 32'h1);
    bus(1'b1, 8'h1C, 32'hFF);
    rd(8'h1C, 32'h0);
    for (int i = 0; i < 8; i++) bus(1'b1, 8'h20 + 8'(4 * i), 32'(3 * i));
    rd(8'h3C, 32'h15);
    bus(1'b1, 8'h10, 32'h2);
    bus(1'b1, 8'h04, 32'h35);
    bus(1'b1, 8'h08, 32'h800);
    // Every selector code, Gaussian product half
    for (int m = 0; m < 4; m++) begin
      go(32'(m) | 32'h4, 32'h50);
      sym(4);
      chk(32'(synth_ctrl.mode), 32'(m));
      chk(32'(synth_ctrl.gauss_on), 32'(m == 1));
      if (m == 1) chk(32'(synth_ctrl.gauss_half), 32'h1);
      chk(32'(deviation_word), m == 3 ? 32'h10 : m == 2 ? 32'h0 : 32'h34);
    end
    // Deviation corners, exponent above 9 held at 9; last two give quarter rate in FSK and GFSK
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, 8'h04, dv[k]);
      go(k == 5 ? 32'h1 : 32'h0, 32'h50);
      sym(2);
      e = (dv[k] >> 4) > 9 ? 9 : int'(dv[k] >> 4);
      chk(32'(deviation_word), 32'(((8 + (dv[k] & 7)) << e) >> 1));
      if (k > 3) chk(32'(deviation_word), 32'h10);
      bus(1'b0, 8'h18, 32'h0);
      chk(32'(r[2]), 32'(k == 3));
    end
    // On-off keying, top index 5
    pattern <= 8'h55;
    go(32'h2, 32'h50);
    sym(8);
    chk(32'(power_level_word), 32'hF);
    chk(32'(synth_ctrl.ask), 32'h0);
    sym(8);
    chk(32'(power_level_word), 32'h0);
    // Amplitude ramp, top index 7, bits 1 1 0 0; 4 steps span 8 cycles
    pattern <= 8'hC3;
    go(32'h2, 32'h71);
    sym(6);
    l1 = power_level_word;
    repeat (8) @(posedge hclk);
    chk(32'(power_level_word - l1), 32'hC);
    chk(32'(synth_ctrl.ask), 32'h1);
    sym(8);
    chk(32'(power_level_word), 32'h15);
    sym(8);
    sym(8);
    chk(32'(power_level_word), 32'h0);
    // Carrier only, with a selector write while running
    go(32'h8, 32'h50);
    bus(1'b1, 8'h00, 32'h1);
    sym(4);
    chk(32'(deviation_word), 32'h0);
    chk(32'(power_level_word), 32'hF);
    chk(32'(synth_ctrl.mode), 32'h0);
    chk(32'(synth_ctrl.active), 32'h1);
    test_done();
  end
endmodule : tb_modulation_control
